// ### bench/dmrm_master_model.sv
// Link master model that drives the register bank's request port
`timescale 1ns/1ns
module dmrm_master_model
(
  input wire logic clk,
  output dmrm_pkg::dmrm_req_s req,
  input wire dmrm_pkg::dmrm_rsp_s rsp
);
  import dmrm_pkg::*;
  initial req = '0;
  // One request, held to its taking edge; answer awaited a few cycles.
  // Unmapped numbers only go out when a bench scenario asks
  task automatic xfer(input logic w, input logic [15:0] a, d,
                      output dmrm_rsp_s r);
    int n;
    @(posedge clk);
    #1;
    req = '{1'b1, w, a, d};
    @(posedge clk);
    #1;
    // Released lines show the inverse, never the last value
    req = '{1'b0, ~w, ~a, ~d};
    n = 0;
    while (!rsp.valid && n < 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    r = rsp;
  endtask
endmodule

// ### bench/dmrm_regmap_bench.sv
// Self-checking bench of the drive register bank
`timescale 1ns/1ns
module dmrm_regmap_bench;
  import dmrm_pkg::*;
  logic clk, rst, flash_commit, single_write_en, recalc_start;
  dmrm_req_s req;
  dmrm_rsp_s rsp, r;
  dmrm_mon_s mon;
  dmrm_ctl_s ctl;
  logic [63:0] coil_status;
  logic [7:0] term_pin, term_active, term_monitor, e;
  logic [15:0] coil_word0, d16, a;
  logic [15:0] lq [2];
  logic [15:0] cmds [3];
  logic [15:0] regs [4], edg [4], k16 [4];
  logic signed [31:0] v, lim;
  logic signed [31:0] keep [3];
  int fails, checked;
  dmrm_regmap dmrm_regmap_i (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
    .mon(mon), .coil_status(coil_status), .term_pin(term_pin), .ctl(ctl),
    .coil_word0(coil_word0), .term_active(term_active),
    .term_monitor(term_monitor), .flash_commit(flash_commit),
    .single_write_en(single_write_en), .recalc_start(recalc_start));
  dmrm_master_model dmrm_master_model_i (.clk(clk), .req(req), .rsp(rsp));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic w, input logic [15:0] ad, d);
    dmrm_master_model_i.xfer(w, ad, d, r);
    chk(r.valid, 1'b1);
    if (r.valid !== 1'b1)
      end_sim();
  endtask
  task automatic wr(input logic [15:0] ad, d, input logic [7:0] ex);
    go(1'b1, ad, d);
    chk(r.exc, ex);
  endtask
  task automatic rd(input logic [15:0] ad, exp);
    go(1'b0, ad, 16'h0000);
    chk({r.exc, r.rdata}, {EXC_NONE, exp});
  endtask
  // Upper half staged first, lower half commits the pair
  task automatic wp(input logic [15:0] ad, input logic [31:0] d,
                    input logic [7:0] ex);
    wr(ad, d[31:16], EXC_NONE);
    wr(ad + 16'h0001, d[15:0], ex);
  endtask
  function automatic logic [7:0] rng(input logic signed [31:0] x, lo, hi);
    return (x < lo || x > hi) ? EXC_VALUE : EXC_NONE;
  endfunction
  // Torque words are signed, limit and option words unsigned
  function automatic logic [7:0] rng16(input logic [15:0] ad, d);
    if (ad == RA_TREF || ad == RA_TBIAS)
      return rng({{16{d[15]}}, d}, -TORQ_LIM, TORQ_LIM);
    if (ad == RA_TLIM)
      return rng({16'h0000, d}, 32'sh0, TORQ_LIM);
    return rng({16'h0000, d}, 32'sh0, {16'h0000, OPO_MAX});
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    mon = '0;
    coil_status = '0;
    term_pin = '0;
    keep = '{32'sh0, 32'sh0, 32'sh0};
    regs = '{RA_TREF, RA_TBIAS, RA_TLIM, RA_OPO};
    edg = '{16'hEC78, 16'hEC77, 16'h1389, 16'h007F};
    k16 = '{default: 16'h0000};
    lq = '{16'h0000, 16'h0000};
    cmds = '{RA_COMMIT, RA_SINGLE, RA_RECALC};
    void'($urandom(32'h514E));
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(ctl.speed_ref, 32'h0000_0000);
    for (int i = 0; i < 3; i++)
    begin
      wr(cmds[i], CMD_ENABLE, EXC_NONE);
      chk({flash_commit, single_write_en, recalc_start}, 3'b100 >> i);
      wr(cmds[i], 16'h0002, EXC_VALUE);
      chk({flash_commit, single_write_en, recalc_start}, 3'b000);
      go(1'b0, cmds[i], 16'h0000);
      chk(r.exc, EXC_ADDR);
    end
    for (int k = 0; k < 3; k++)
      for (int i = 0; i < 10; i++)
      begin
        lim = k ? PID_LIM : SPEED_LIM;
        a = k == 2 ? RA_PIDF_HI : k ? RA_PIDT_HI : RA_SPEED_HI;
        v = i == 0 ? lim : i == 1 ? -lim : i == 2 ? lim + 1 :
          i == 3 ? -lim - 1 : $signed($urandom_range(2 * lim)) - lim;
        e = rng(v, -lim, lim);
        wp(a, v, e);
        if (e == EXC_NONE)
          keep[k] = v;
        chk(k == 2 ? ctl.pid_feedback : k ? ctl.pid_target :
          ctl.speed_ref, keep[k]);
        rd(a, keep[k][31:16]);
        rd(a + 16'h0001, keep[k][15:0]);
      end
    for (int i = 0; i < 6; i++)
    begin
      a = i[0] ? RA_REV_LIM : RA_FWD_LIM;
      d16 = i == 0 ? 16'hE678 : i == 1 ? 16'hE679 :
        16'($urandom_range(59000));
      wr(a, d16, i == 1 ? EXC_VALUE : EXC_NONE);
      if (i != 1)
        lq[i[0]] = d16;
      rd(a, lq[i[0]]);
    end
    for (int i = 0; i < 16; i++)
    begin
      a = regs[i % 4];
      d16 = i < 4 ? edg[i] : i[2] ? 16'($urandom_range(127)) :
        16'($urandom());
      e = rng16(a, d16);
      wr(a, d16, e);
      if (e == EXC_NONE)
        k16[i % 4] = d16;
      chk(i % 4 == 0 ? ctl.torque_ref : i % 4 == 1 ? ctl.torque_bias :
        i % 4 == 2 ? ctl.torque_limit : ctl.option_output_function, k16[i % 4]);
      rd(a, k16[i % 4]);
    end
    d16 = 16'($urandom());
    coil_status = {$urandom(), $urandom()};
    wr(RA_COIL0, d16, EXC_NONE);
    chk(coil_word0, d16 & COIL0_MASK);
    rd(RA_COIL0, d16 & COIL0_MASK);
    for (int j = 0; j < 4; j++)
    begin
      rd(RA_COIL1 + 16'(j), coil_status[16 * j +: 16]);
      wr(RA_COIL1 + 16'(j), 16'h0001, EXC_ADDR);
    end
    mon.out_freq = 16'($urandom_range(59000));
    mon.signed_freq = $signed($urandom_range(118000)) - 59000;
    mon.upper_limit = 16'($urandom_range(59000));
    rd(RA_OUT_FREQ, mon.out_freq);
    wr(RA_OUT_FREQ, 16'h0001, EXC_ADDR);
    mon.out_current = 16'($urandom());
    mon.freq_ref = $urandom();
    mon.scaled_freq = $urandom();
    mon.detected_speed = $urandom();
    rd(RA_OUT_CURR, mon.out_current);
    rd(RA_FREF_HI, mon.freq_ref[31:16]);
    rd(RA_FREF_LO, mon.freq_ref[15:0]);
    rd(RA_SCALE_HI, mon.scaled_freq[31:16]);
    rd(RA_SCALE_LO, mon.scaled_freq[15:0]);
    rd(RA_DSPD_HI, mon.detected_speed[31:16]);
    rd(RA_DSPD_LO, mon.detected_speed[15:0]);
    go(1'b0, 16'h2928, 16'h0000);
    chk(r.exc, EXC_ADDR);
    for (int i = 0; i < 4; i++)
    begin
      mon.direction = 2'(i);
      rd(RA_DIR_MON, 16'(i));
    end
    rd(RA_SFREQ_HI, mon.signed_freq[31:16]);
    rd(RA_SFREQ_LO, mon.signed_freq[15:0]);
    rd(RA_UPLIM, mon.upper_limit);
    wr(RA_UPLIM, 16'h0000, EXC_ADDR);
    term_pin = 8'($urandom());
    repeat (3) @(posedge clk);
    #1;
    chk(term_monitor, term_pin);
    chk(term_active, term_pin | coil_word0[12:5]);
    end_sim();
  end
endmodule

// ### bench/dmrm_regmap_monitor.sv
// Checker of the drive register bank's ports
`timescale 1ns/1ns
module dmrm_regmap_monitor
(
  input wire logic clk,
  input wire logic rst,
  input wire dmrm_pkg::dmrm_req_s req,
  input wire dmrm_pkg::dmrm_rsp_s rsp,
  input wire dmrm_pkg::dmrm_mon_s mon,
  input wire logic [dmrm_pkg::COIL_HI_W-1:0] coil_status,
  input wire logic [dmrm_pkg::TERM_W-1:0] term_pin,
  input wire dmrm_pkg::dmrm_ctl_s ctl,
  input wire logic [15:0] coil_word0,
  input wire logic [dmrm_pkg::TERM_W-1:0] term_active,
  input wire logic [dmrm_pkg::TERM_W-1:0] term_monitor,
  input wire logic flash_commit,
  input wire logic single_write_en,
  input wire logic recalc_start
);
  import dmrm_pkg::*;
  logic wr, rd;
  assign wr = req.valid && req.write;
  assign rd = req.valid && !req.write;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rsp_latency: assert property (req.valid |=> rsp.valid)
    else $error("answer missing one cycle after request");
  a_commit_pulse: assert property (wr && req.addr == RA_COMMIT &&
    req.wdata == CMD_ENABLE |=> flash_commit)
    else $error("commit pulse missing");
  a_commit_cause: assert property (flash_commit |->
    $past(wr) && $past(req.addr) == RA_COMMIT)
    else $error("commit pulse without commit write");
  a_cmd_wonly: assert property (rd && req.addr == RA_COMMIT |=>
    rsp.err && rsp.exc == EXC_ADDR)
    else $error("command register read not refused");
  a_monitor_ro: assert property (wr && req.addr inside
    {[RA_OUT_FREQ:RA_UPLIM]} |=> rsp.err && rsp.exc == EXC_ADDR)
    else $error("monitor write not refused");
  a_coil_ro: assert property (wr && req.addr inside
    {[RA_COIL1:RA_COIL4]} |=> rsp.exc == EXC_ADDR && $stable(coil_word0))
    else $error("coil word write not refused");
  a_dir_read: assert property (rd && req.addr == RA_DIR_MON |=>
    rsp.rdata == {14'h0000, $past(mon.direction)})
    else $error("direction read wrong");
  a_speed_bound: assert property ($signed(ctl.speed_ref) <= SPEED_LIM &&
    $signed(ctl.speed_ref) >= -SPEED_LIM)
    else $error("speed reference out of range");
  a_pid_bound: assert property ($signed(ctl.pid_target) <= PID_LIM &&
    $signed(ctl.pid_target) >= -PID_LIM)
    else $error("pid target out of range");
  a_term_or: assert property (term_active ==
    ($past(coil_word0[12:5]) | $past(term_monitor)))
    else $error("terminal state not coil or pin");
  c_commit: cover property (flash_commit);
  c_bad_value: cover property (rsp.valid && rsp.exc == EXC_VALUE);
  c_speed_set: cover property (!$stable(ctl.speed_ref));
endmodule
bind dmrm_regmap dmrm_regmap_monitor dmrm_regmap_monitor_i (.clk(clk),
  .rst(rst), .req(req), .rsp(rsp), .mon(mon), .coil_status(coil_status),
  .term_pin(term_pin), .ctl(ctl), .coil_word0(coil_word0),
  .term_active(term_active), .term_monitor(term_monitor),
  .flash_commit(flash_commit), .single_write_en(single_write_en),
  .recalc_start(recalc_start));

// ### hdl/dmrm_pkg.sv
// Package: register map, field layout, limits and carriers of the drive map
package dmrm_pkg;

  // ----------------------------------------------------------------
  // Holding register numbers
  // ----------------------------------------------------------------
  localparam logic [15:0] RA_OUT_FREQ = 16'h2711;
  localparam logic [15:0] RA_OUT_CURR = 16'h2712;
  localparam logic [15:0] RA_DIR_MON = 16'h2713;
  localparam logic [15:0] RA_FREF_HI = 16'h2714;
  localparam logic [15:0] RA_FREF_LO = RA_FREF_HI + 16'h0001;
  localparam logic [15:0] RA_SCALE_HI = 16'h2716;
  localparam logic [15:0] RA_SCALE_LO = RA_SCALE_HI + 16'h0001;
  localparam logic [15:0] RA_DSPD_HI = 16'h2718;
  localparam logic [15:0] RA_DSPD_LO = RA_DSPD_HI + 16'h0001;
  localparam logic [15:0] RA_SFREQ_HI = 16'h271C;
  localparam logic [15:0] RA_SFREQ_LO = RA_SFREQ_HI + 16'h0001;
  localparam logic [15:0] RA_UPLIM = 16'h271E;
  localparam logic [15:0] RA_COMMIT = 16'h2328;
  localparam logic [15:0] RA_SINGLE = 16'h232A;
  localparam logic [15:0] RA_RECALC = 16'h2332;
  localparam logic [15:0] RA_SPEED_HI = 16'h2906;
  localparam logic [15:0] RA_SPEED_LO = RA_SPEED_HI + 16'h0001;
  localparam logic [15:0] RA_TREF = 16'h291E;
  localparam logic [15:0] RA_TBIAS = 16'h2922;
  localparam logic [15:0] RA_FWD_LIM = 16'h2926;
  localparam logic [15:0] RA_REV_LIM = 16'h2927;
  localparam logic [15:0] RA_PIDT_HI = 16'h2932;
  localparam logic [15:0] RA_PIDT_LO = RA_PIDT_HI + 16'h0001;
  localparam logic [15:0] RA_PIDF_HI = 16'h293A;
  localparam logic [15:0] RA_PIDF_LO = RA_PIDF_HI + 16'h0001;
  localparam logic [15:0] RA_TLIM = 16'h2946;
  localparam logic [15:0] RA_OPO = 16'h3EB5;
  localparam logic [15:0] RA_COIL0 = 16'h3EBC;
  localparam logic [15:0] RA_COIL1 = 16'h3EBD;
  localparam logic [15:0] RA_COIL4 = 16'h3EC0;

  // ----------------------------------------------------------------
  // Data limits, command code, coil layout, answers
  // ----------------------------------------------------------------
  localparam logic signed [31:0] SPEED_LIM = 32'sh0000E678;
  localparam logic signed [31:0] TORQ_LIM = 32'sh00001388;
  localparam logic signed [31:0] PID_LIM = 32'sh00002710;
  localparam logic [15:0] OPO_MAX = 16'h007F;
  localparam logic [15:0] CMD_ENABLE = 16'h0001;
  localparam logic [15:0] COIL0_MASK = 16'h1FFE;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam int TERM_LO = 5;
  localparam int TERM_W = 8;
  localparam int COIL_HI_W = 64;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;

  typedef enum logic [3:0] {
    W_NONE, W_COMMIT, W_SINGLE, W_RECALC, W_STAGE, W_SPEED, W_TREF,
    W_TBIAS, W_FWD, W_REV, W_PIDT, W_PIDF, W_TLIM, W_OPO, W_COIL0
  } dmrm_wsel_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dmrm_req_s;

  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] exc;
    logic [15:0] rdata;
  } dmrm_rsp_s;

  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] out_current;
    logic [1:0] direction;
    logic [31:0] freq_ref;
    logic [31:0] scaled_freq;
    logic [31:0] detected_speed;
    logic [31:0] signed_freq;
    logic [15:0] upper_limit;
  } dmrm_mon_s;

  typedef struct packed {
    logic [31:0] speed_ref;
    logic [15:0] torque_ref;
    logic [15:0] torque_bias;
    logic [15:0] fwd_limit;
    logic [15:0] rev_limit;
    logic [31:0] pid_target;
    logic [31:0] pid_feedback;
    logic [15:0] torque_limit;
    logic [15:0] option_output_function;
  } dmrm_ctl_s;

endpackage

// ### hdl/dmrm_regmap.sv
// Holding-register bank of the drive, seen from the link's request port
`timescale 1ns/1ns

// Behaviour
// - Writing 0001 to the commit register starts a store of all parameters.
// - The speed reference pair is read/write and holds -59000 to 59000.
// - Forward and reverse speed limits are read/write, 0 to 59000 each.
// - The PID target pair is read/write and holds -10000 to 10000.
// - Coil word 0 carries coils 0 to 15 and is read/write.
// - Coil words 1 to 4 carry coils 16 to 79 and are read-only.
// - Monitor registers and coil words 1 to 4 are read-only, command registers write-only, other registers read and write.
// - The direction monitor reports a code of 0 to 3.
// - The signed output frequency is a two-register pair.
// - The upper frequency limit monitor is read-only, 0 to 59000.
// - A terminal is on when its coil or its pin is on; monitor sees pins.
module dmrm_regmap
(
  input wire logic clk,
  input wire logic rst,
  input wire dmrm_pkg::dmrm_req_s req,
  output dmrm_pkg::dmrm_rsp_s rsp,
  input wire dmrm_pkg::dmrm_mon_s mon,
  input wire logic [dmrm_pkg::COIL_HI_W-1:0] coil_status,
  input wire logic [dmrm_pkg::TERM_W-1:0] term_pin,
  output dmrm_pkg::dmrm_ctl_s ctl,
  output logic [15:0] coil_word0,
  output logic [dmrm_pkg::TERM_W-1:0] term_active,
  output logic [dmrm_pkg::TERM_W-1:0] term_monitor,
  output logic flash_commit,
  output logic single_write_en,
  output logic recalc_start
);
  import dmrm_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  dmrm_ctl_s ctl_q;
  dmrm_rsp_s rsp_q;
  logic [15:0] stage_q;
  logic [15:0] coil0_q;
  logic [TERM_W-1:0] pin_s1_q;
  logic [TERM_W-1:0] pin_s2_q;
  logic [TERM_W-1:0] term_act_q;
  logic commit_q;
  logic single_q;
  logic recalc_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [15:0] rd_d;
  logic hit;
  logic ro;
  logic wo;
  logic val_ok;
  logic [7:0] exc_d;
  logic do_wr;
  logic [31:0] pair_d;
  logic signed [31:0] wsext;
  dmrm_wsel_e wsel;

  function automatic logic in_sym(input logic signed [31:0] v,
                                  input logic signed [31:0] lim);
    return (v >= -lim) && (v <= lim);
  endfunction

  // Upper half staged first, lower half completes the pair
  assign pair_d = {stage_q, req.wdata};
  assign wsext = {{16{req.wdata[15]}}, req.wdata};

  // Monitor block and coil words 1..4 refuse writes
  assign ro = (req.addr >= RA_OUT_FREQ && req.addr <= RA_UPLIM) ||
              (req.addr >= RA_COIL1 && req.addr <= RA_COIL4);
  assign wo = (req.addr == RA_COMMIT) || (req.addr == RA_SINGLE) ||
              (req.addr == RA_RECALC);

  always_comb
  begin
    rd_d = 16'h0000;
    hit = 1'b1;
    case (req.addr)
      RA_OUT_FREQ: rd_d = mon.out_freq;
      RA_OUT_CURR: rd_d = mon.out_current;
      RA_DIR_MON: rd_d = {14'h0000, mon.direction};
      RA_FREF_HI: rd_d = mon.freq_ref[31:16];
      RA_FREF_LO: rd_d = mon.freq_ref[15:0];
      RA_SCALE_HI: rd_d = mon.scaled_freq[31:16];
      RA_SCALE_LO: rd_d = mon.scaled_freq[15:0];
      RA_DSPD_HI: rd_d = mon.detected_speed[31:16];
      RA_DSPD_LO: rd_d = mon.detected_speed[15:0];
      RA_SFREQ_HI: rd_d = mon.signed_freq[31:16];
      RA_SFREQ_LO: rd_d = mon.signed_freq[15:0];
      RA_UPLIM: rd_d = mon.upper_limit;
      RA_COMMIT: rd_d = 16'h0000;
      RA_SINGLE: rd_d = 16'h0000;
      RA_RECALC: rd_d = 16'h0000;
      RA_SPEED_HI: rd_d = ctl_q.speed_ref[31:16];
      RA_SPEED_LO: rd_d = ctl_q.speed_ref[15:0];
      RA_TREF: rd_d = ctl_q.torque_ref;
      RA_TBIAS: rd_d = ctl_q.torque_bias;
      RA_FWD_LIM: rd_d = ctl_q.fwd_limit;
      RA_REV_LIM: rd_d = ctl_q.rev_limit;
      RA_PIDT_HI: rd_d = ctl_q.pid_target[31:16];
      RA_PIDT_LO: rd_d = ctl_q.pid_target[15:0];
      RA_PIDF_HI: rd_d = ctl_q.pid_feedback[31:16];
      RA_PIDF_LO: rd_d = ctl_q.pid_feedback[15:0];
      RA_TLIM: rd_d = ctl_q.torque_limit;
      RA_OPO: rd_d = ctl_q.option_output_function;
      RA_COIL0: rd_d = coil0_q;
      RA_COIL1: rd_d = coil_status[15:0];
      RA_COIL1 + 16'h0001: rd_d = coil_status[31:16];
      RA_COIL1 + 16'h0002: rd_d = coil_status[47:32];
      RA_COIL4: rd_d = coil_status[63:48];
      // Gaps answer illegal address rather than alias a neighbour
      default: hit = 1'b0;
    endcase
  end

  always_comb
  begin
    wsel = W_NONE;
    case (req.addr)
      RA_COMMIT: wsel = W_COMMIT;
      RA_SINGLE: wsel = W_SINGLE;
      RA_RECALC: wsel = W_RECALC;
      RA_SPEED_HI: wsel = W_STAGE;
      RA_SPEED_LO: wsel = W_SPEED;
      RA_TREF: wsel = W_TREF;
      RA_TBIAS: wsel = W_TBIAS;
      RA_FWD_LIM: wsel = W_FWD;
      RA_REV_LIM: wsel = W_REV;
      RA_PIDT_HI: wsel = W_STAGE;
      RA_PIDT_LO: wsel = W_PIDT;
      RA_PIDF_HI: wsel = W_STAGE;
      RA_PIDF_LO: wsel = W_PIDF;
      RA_TLIM: wsel = W_TLIM;
      RA_OPO: wsel = W_OPO;
      RA_COIL0: wsel = W_COIL0;
      default: wsel = W_NONE;
    endcase
  end

  // Out-of-range data is refused and leaves the old value in place
  always_comb
  begin
    val_ok = 1'b1;
    case (wsel)
      W_COMMIT: val_ok = req.wdata == CMD_ENABLE;
      W_SINGLE: val_ok = req.wdata == CMD_ENABLE;
      W_RECALC: val_ok = req.wdata == CMD_ENABLE;
      W_SPEED: val_ok = in_sym(pair_d, SPEED_LIM);
      W_TREF: val_ok = in_sym(wsext, TORQ_LIM);
      W_TBIAS: val_ok = in_sym(wsext, TORQ_LIM);
      W_FWD: val_ok = req.wdata <= SPEED_LIM[15:0];
      W_REV: val_ok = req.wdata <= SPEED_LIM[15:0];
      W_PIDT: val_ok = in_sym(pair_d, PID_LIM);
      W_PIDF: val_ok = in_sym(pair_d, PID_LIM);
      W_TLIM: val_ok = req.wdata <= TORQ_LIM[15:0];
      W_OPO: val_ok = req.wdata <= OPO_MAX;
      default: val_ok = 1'b1;
    endcase
  end

  // Address faults outrank data faults, so a bad number never reads as 03
  always_comb
  begin
    exc_d = EXC_NONE;
    if (!hit)
      exc_d = EXC_ADDR;
    else if (req.write && ro)
      exc_d = EXC_ADDR;
    else if (!req.write && wo)
      exc_d = EXC_ADDR;
    else if (req.write && !val_ok)
      exc_d = EXC_VALUE;
  end

  assign do_wr = req.valid && req.write && (exc_d == EXC_NONE);

  // ----------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rsp_q <= '0;
    else
    begin
      rsp_q.valid <= req.valid;
      rsp_q.err <= req.valid && (exc_d != EXC_NONE);
      rsp_q.exc <= req.valid ? exc_d : EXC_NONE;
      if (req.valid && !req.write && exc_d == EXC_NONE)
        rsp_q.rdata <= rd_d;
      else
        rsp_q.rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // One staging word is shared by all pairs: write high, then low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stage_q <= CTL_RESET;
    else if (do_wr && wsel == W_STAGE)
      stage_q <= req.wdata;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctl_q <= '0;
    else if (do_wr)
    begin
      case (wsel)
        W_SPEED: ctl_q.speed_ref <= pair_d;
        W_TREF: ctl_q.torque_ref <= req.wdata;
        W_TBIAS: ctl_q.torque_bias <= req.wdata;
        W_FWD: ctl_q.fwd_limit <= req.wdata;
        W_REV: ctl_q.rev_limit <= req.wdata;
        W_PIDT: ctl_q.pid_target <= pair_d;
        W_PIDF: ctl_q.pid_feedback <= pair_d;
        W_TLIM: ctl_q.torque_limit <= req.wdata;
        W_OPO: ctl_q.option_output_function <= req.wdata;
        default: ctl_q <= ctl_q;
      endcase
    end
  end

  // Reserved coils 0 and 13..15 are not stored
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      coil0_q <= CTL_RESET;
    else if (do_wr && wsel == W_COIL0)
      coil0_q <= req.wdata & COIL0_MASK;
  end

  // ----------------------------------------------------------------
  // Command pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      commit_q <= 1'b0;
      single_q <= 1'b0;
      recalc_q <= 1'b0;
    end
    else
    begin
      commit_q <= do_wr && wsel == W_COMMIT;
      single_q <= do_wr && wsel == W_SINGLE;
      recalc_q <= do_wr && wsel == W_RECALC;
    end
  end

  // ----------------------------------------------------------------
  // Input terminals
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= term_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Coil or pin turns a terminal on; monitor shows pins only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      term_act_q <= '0;
    else
      term_act_q <= coil0_q[TERM_LO +: TERM_W] | pin_s2_q;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // All leave through flops; the answer costs one cycle of latency
  assign rsp = rsp_q;
  assign ctl = ctl_q;
  assign coil_word0 = coil0_q;
  assign term_active = term_act_q;
  assign term_monitor = pin_s2_q;
  assign flash_commit = commit_q;
  assign single_write_en = single_q;
  assign recalc_start = recalc_q;

endmodule
